// >>> verilog/fpc_pkg.sv
package fpc_pkg;

	// ****************************************
	// keypad codes
	// ****************************************
	localparam logic [3:0] KEY_MENU = 4'hA;
	localparam logic [3:0] KEY_1    = 4'h1;
	localparam logic [3:0] KEY_2    = 4'h2;
	localparam logic [3:0] KEY_3    = 4'h3;
	localparam logic [3:0] KEY_4    = 4'h4;
	localparam logic [3:0] KEY_5    = 4'h5;
	localparam logic [3:0] KEY_6    = 4'h6;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_NOMFREQ = 8'h04;
	localparam logic [7:0] OFS_MUXSEL  = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;
	localparam logic [7:0] OFS_MEASCNT = 8'h10;
	localparam logic [7:0] OFS_OFFSET  = 8'h14;
	localparam logic [7:0] OFS_EVIDX   = 8'h18;
	localparam logic [7:0] OFS_EVD0    = 8'h1C;
	localparam logic [7:0] OFS_EVD1    = 8'h20;
	localparam logic [7:0] OFS_EVD2    = 8'h24;

	// ctrl field positions
	localparam int CTL_MEAS = 0;
	localparam int CTL_LOG  = 1;
	localparam int CTL_DST  = 2;
	localparam int CTL_LOCK = 3;
	localparam int CTL_EDGE = 4;
	localparam int CTL_CLR  = 8;

	// ****************************************
	// limits and codes
	// ****************************************
	localparam logic [26:0] NOM_MIN     = 27'h000_0001;
	localparam logic [26:0] NOM_MAX     = 27'h098_9680; // ten million
	localparam logic [23:0] NOM_RESET   = 24'h98_9680;
	localparam logic [15:0] UNLOCK_CODE = 16'h9975;     // four bcd digits
	localparam logic [13:0] MANT_TOP    = 14'h270F;     // 9999
	localparam logic [13:0] MANT_ROLL   = 14'h0064;     // 100
	localparam logic [39:0] OFS_E14_LIM = 40'h00_0000_2710; // 1e4
	localparam logic [39:0] OFS_E12_LIM = 40'h00_000F_4240; // 1e6
	localparam logic [39:0] OFS_MAX     = 40'h00_3B9A_CA00; // 1e9 = 1e-5
	localparam logic [7:0]  EVENT_STATUS_NORMAL = 8'h00;
	localparam int SRC_TRACKING = 11;
	localparam int SRC_LOCKED   = 12;
	localparam int SRC_HIGH     = 13;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {SCR_FREQ, SCR_EVLOG, SCR_DST, SCR_MUX} fpc_screen_t;
	typedef enum logic [1:0] {IND_NONE, IND_NOT_LOCKED_INDICATOR, IND_STAR} fpc_meas_ind_t;
	typedef enum logic [1:0] {SC_E09, SC_E12, SC_E14} fpc_scale_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  code;
	} fpc_key_t;

	typedef struct packed {
		logic [8:0]  day;
		logic [4:0]  hour;
		logic [5:0]  min;
		logic [5:0]  sec;
		logic [27:0] sub;  // seven bcd digits
	} fpc_tod_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [15:0] evnum;
		logic [1:0]  chan;
		fpc_tod_t    tod;
	} fpc_event_t;

endpackage : fpc_pkg

// >>> verilog/fpc_evmem.sv
`timescale 1ns/10ps
// ****************************************
// event store, registered read
// ****************************************
module fpc_evmem #(
	parameter int W     = 80,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic          pclk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_ff
);
	logic [W-1:0] mem [DEPTH];

	// write port and registered read port
	always_ff @(posedge pclk)
	begin
		if (ce)
		begin
			if (we)
				mem[waddr] <= wdata;
			rdata_ff <= mem[raddr];
		end
	end
endmodule : fpc_evmem

// >>> verilog/fpc_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - measurement enable disables the event log and interval measurement.
// - key one plus eight digits sets nominal frequency, 1 to 10000000.
// - on frequency screen key two enables, key three disables measurement.
// - indicator: not-locked when unlocked, asterisk when tracking, blank if off.
// - count steps each second while locked, four-digit mantissa, rolls 9999 to 0100+02.
// - offset scaled to E-09, E-12, E-14; out of range beyond 1e-5 or noisy.
// - external frequency divided by nominal value into one pulse per second.
// - event screen key one stops, key two clears, key four starts logging.
// - key three steps three-digit edge field; only channel one digit acts.
// - key five shows previous event, key six the next event.
// - event holds status, number, channel, day, hours, minutes, seconds, subseconds.
// - log indicator is asterisk while logging, blank otherwise.
// - key one on daylight screen toggles automatic daylight saving.
// - key one on mux screen cycles selected channel one to four.
// - channels one and two feed two connectors, three and four one each.
// - key two cycles selected channel's sixteen-way source.
// - tracking source high when tracking, locked source high when locked.
// - mux selections read and written over the bus with the same effect.
// - lock off after reset; key three on mux screen turns it on.
// - while locked every key is ignored but menu, key three on the mux screen and the unlock code digits.
// - key three then code 9975 on mux screen clears the lock.
module fpc_ctrl
	import fpc_pkg::*;
#(
	parameter int LOG_DEPTH = 16,
	parameter int LOG_AW    = 4
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata_ff,
	output logic                    pready_ff,
	output logic                    pslverr_ff,
	input  wire fpc_pkg::fpc_key_t  key,
	input  wire logic               pps_tick,
	input  wire logic               tracking,
	input  wire logic               locked,
	input  wire logic               ext_freq_in,
	input  wire logic signed [39:0] offset_in,
	input  wire logic               offset_noisy,
	input  wire logic               event_in,
	input  wire fpc_pkg::fpc_tod_t  tod,
	input  wire logic [15:0]        mux_src,
	output logic [5:0]              conn_out_ff,
	output logic                    ext_pps_ff,
	output logic                    ti_enable_ff,
	output logic                    dst_enable_ff,
	output fpc_pkg::fpc_meas_ind_t  meas_ind_ff,
	output logic                    log_ind_ff
);
	import fpc_pkg::*;

	// ****************************************
	// state
	// ****************************************
	fpc_screen_t      screen_ff;
	logic             meas_en_ff, log_en_ff, lock_ff;
	logic [2:0]       edge_sel_ff;
	logic [23:0]      nom_ff;
	logic [1:0]       ch_sel_ff;
	logic [3:0]       mux_sel_ff [4];
	logic [3:0]       mux_out_ff;
	logic             freq_entry_ff, code_entry_ff;
	logic [26:0]      acc_ff;
	logic [15:0]      code_ff;
	logic [3:0]       digits_ff;
	logic [23:0]      div_cnt_ff;
	logic             ext_d_ff, ev_d_ff;
	logic [13:0]      mant_ff;
	logic [3:0]       exp_ff;
	logic [31:0]      sub_ff, step_ff;
	fpc_scale_t       scale_ff;
	logic             oor_ff;
	logic [15:0]      ofs_mant_ff;
	logic             ofs_neg_ff;
	logic [LOG_AW:0]  ev_cnt_ff;
	logic [LOG_AW-1:0] view_ff;
	fpc_event_t       ev_rd;
	logic             ev_we, ev_edge, clr_log;
	logic             kv, wr_en, rd_en;
	logic [26:0]      acc_next;
	logic [39:0]      ofs_abs;

	// a key counts when valid and the lock lets it through
	assign kv = key.valid && (!lock_ff || key.code == KEY_MENU || code_entry_ff
		|| (screen_ff == SCR_MUX && key.code == KEY_3));
	assign wr_en = psel && penable && pready_ff && pwrite;
	assign rd_en = psel && !penable;

	// ****************************************
	// screen and digit entry
	// ****************************************
	// menu key steps through the screens handled here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			screen_ff <= SCR_FREQ;
		else if (ce && kv && key.code == KEY_MENU && !freq_entry_ff && !code_entry_ff)
			screen_ff <= fpc_screen_t'(screen_ff + 2'd1);
	end

	assign acc_next = 27'(acc_ff * 27'd10) + {23'd0, key.code};

	// eight-digit frequency entry and four-digit unlock code entry
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			freq_entry_ff <= 1'b0;
			code_entry_ff <= 1'b0;
			acc_ff        <= '0;
			code_ff       <= '0;
			digits_ff     <= '0;
		end
		else if (ce && kv)
		begin
			if (key.code == KEY_MENU)
			begin
				freq_entry_ff <= 1'b0;   // menu abandons an entry
				code_entry_ff <= 1'b0;
			end
			else if (freq_entry_ff)
			begin
				acc_ff    <= acc_next;
				digits_ff <= digits_ff + 4'd1;
				if (digits_ff == 4'd7)
					freq_entry_ff <= 1'b0;
			end
			else if (code_entry_ff)
			begin
				code_ff   <= {code_ff[11:0], key.code};
				digits_ff <= digits_ff + 4'd1;
				if (digits_ff == 4'd3)
					code_entry_ff <= 1'b0;
			end
			else if (screen_ff == SCR_FREQ && key.code == KEY_1)
			begin
				freq_entry_ff <= 1'b1;
				acc_ff        <= '0;
				digits_ff     <= '0;
			end
			else if (screen_ff == SCR_MUX && key.code == KEY_3 && lock_ff)
			begin
				code_entry_ff <= 1'b1;
				code_ff       <= '0;
				digits_ff     <= '0;
			end
		end
	end

	// nominal frequency, range checked on the eighth digit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nom_ff <= NOM_RESET;
		else if (ce)
		begin
			if (kv && freq_entry_ff && digits_ff == 4'd7 && key.code != KEY_MENU
				&& acc_next >= NOM_MIN && acc_next <= NOM_MAX)
				nom_ff <= acc_next[23:0];
			else if (wr_en && paddr == OFS_NOMFREQ && pwdata[26:0] >= NOM_MIN
				&& pwdata[26:0] <= NOM_MAX)
				nom_ff <= pwdata[23:0];
		end
	end

	// ****************************************
	// control flags
	// ****************************************
	// measurement, logging, daylight, lock and edge field
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meas_en_ff    <= 1'b0;
			log_en_ff     <= 1'b0;
			dst_enable_ff <= 1'b0;
			lock_ff       <= 1'b0;
			edge_sel_ff   <= '0;
		end
		else if (ce)
		begin
			if (wr_en && paddr == OFS_CTRL)
			begin
				meas_en_ff    <= pwdata[CTL_MEAS];
				log_en_ff     <= pwdata[CTL_LOG];
				dst_enable_ff <= pwdata[CTL_DST];
				lock_ff       <= pwdata[CTL_LOCK];
				edge_sel_ff   <= pwdata[CTL_EDGE +: 3];
			end
			else if (kv && !freq_entry_ff && !code_entry_ff)
			begin
				unique case (screen_ff)
					SCR_FREQ:
					begin
						if (key.code == KEY_2)
							meas_en_ff <= 1'b1;
						else if (key.code == KEY_3)
							meas_en_ff <= 1'b0;
					end
					SCR_EVLOG:
					begin
						if (key.code == KEY_1)
							log_en_ff <= 1'b0;
						else if (key.code == KEY_4)
							log_en_ff <= 1'b1;
						else if (key.code == KEY_3)
							edge_sel_ff <= edge_sel_ff + 3'd1;
					end
					SCR_DST:
						if (key.code == KEY_1)
							dst_enable_ff <= !dst_enable_ff;
					SCR_MUX:
						if (key.code == KEY_3 && !lock_ff)
							lock_ff <= 1'b1;
				endcase
			end
			else if (kv && code_entry_ff && digits_ff == 4'd3
				&& {code_ff[11:0], key.code} == UNLOCK_CODE)
				lock_ff <= 1'b0;
		end
	end

	// ****************************************
	// mux selection per channel
	// ****************************************
	// channel pointer and source select, keypad or bus
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ch_sel_ff <= '0;
			for (int i = 0; i < 4; i++)
				mux_sel_ff[i] <= '0;
		end
		else if (ce)
		begin
			if (wr_en && paddr == OFS_MUXSEL)
			begin
				for (int i = 0; i < 4; i++)
					mux_sel_ff[i] <= pwdata[4*i +: 4];
			end
			else if (kv && screen_ff == SCR_MUX && !code_entry_ff)
			begin
				if (key.code == KEY_1)
					ch_sel_ff <= ch_sel_ff + 2'd1;
				else if (key.code == KEY_2)
					mux_sel_ff[ch_sel_ff] <= mux_sel_ff[ch_sel_ff] + 4'd1;
			end
		end
	end

	// one sixteen-way mux per channel
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_mux
			logic [15:0] src;
			always_comb
			begin
				src               = mux_src;
				src[SRC_TRACKING] = tracking;
				src[SRC_LOCKED]   = locked;
				src[SRC_HIGH]     = 1'b1;
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mux_out_ff[g] <= 1'b0;
				else if (ce)
					mux_out_ff[g] <= src[mux_sel_ff[g]];
			end
		end
	endgenerate

	// connector fan-out: j4,j9 / j5,j8 / j6 / j7
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conn_out_ff <= '0;
		else if (ce)
			conn_out_ff <= {mux_out_ff[0], mux_out_ff[1], mux_out_ff[3],
				mux_out_ff[2], mux_out_ff[1], mux_out_ff[0]};
	end

	// ****************************************
	// frequency measurement
	// ****************************************
	// divide external input down to one pulse per second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_d_ff   <= 1'b0;
			div_cnt_ff <= '0;
			ext_pps_ff <= 1'b0;
		end
		else if (ce)
		begin
			ext_d_ff   <= ext_freq_in;
			ext_pps_ff <= 1'b0;
			if (!meas_en_ff)
				div_cnt_ff <= '0;
			else if (ext_freq_in && !ext_d_ff)
			begin
				if (div_cnt_ff >= nom_ff - 24'd1)
				begin
					div_cnt_ff <= '0;
					ext_pps_ff <= 1'b1;
				end
				else
					div_cnt_ff <= div_cnt_ff + 24'd1;
			end
		end
	end

	// auto-scaled seconds count: mantissa steps every step_ff seconds
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mant_ff <= '0;
			exp_ff  <= '0;
			sub_ff  <= '0;
			step_ff <= 32'h0000_0001;
		end
		else if (ce)
		begin
			if (!meas_en_ff)
			begin
				mant_ff <= '0;
				exp_ff  <= '0;
				sub_ff  <= '0;
				step_ff <= 32'h0000_0001;
			end
			else if (pps_tick && locked)
			begin
				if (sub_ff + 32'd1 >= step_ff)
				begin
					sub_ff <= '0;
					if (mant_ff == MANT_TOP)
					begin
						mant_ff <= MANT_ROLL;
						exp_ff  <= exp_ff + 4'd2;
						step_ff <= 32'(step_ff * 32'd100);
					end
					else
						mant_ff <= mant_ff + 14'd1;
				end
				else
					sub_ff <= sub_ff + 32'd1;
			end
		end
	end

	// offset magnitude in units of 1e-14
	assign ofs_abs = offset_in[39] ? 40'(-offset_in) : offset_in;

	// offset scaling and out-of-range flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scale_ff    <= SC_E14;
			ofs_mant_ff <= '0;
			ofs_neg_ff  <= 1'b0;
			oor_ff      <= 1'b0;
		end
		else if (ce)
		begin
			ofs_neg_ff <= offset_in[39];
			oor_ff     <= meas_en_ff && (ofs_abs > OFS_MAX || offset_noisy);
			if (ofs_abs < OFS_E14_LIM)
			begin
				scale_ff    <= SC_E14;
				ofs_mant_ff <= ofs_abs[15:0];
			end
			else if (ofs_abs < OFS_E12_LIM)
			begin
				scale_ff    <= SC_E12;
				ofs_mant_ff <= 16'(ofs_abs / 40'd100);
			end
			else
			begin
				scale_ff    <= SC_E09;
				ofs_mant_ff <= 16'(ofs_abs / 40'd100000);
			end
		end
	end

	// status indicators and shared input steering
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meas_ind_ff  <= IND_NONE;
			log_ind_ff   <= 1'b0;
			ti_enable_ff <= 1'b1;
		end
		else if (ce)
		begin
			ti_enable_ff <= !meas_en_ff;
			log_ind_ff   <= log_en_ff && !meas_en_ff;
			if (!meas_en_ff)
				meas_ind_ff <= IND_NONE;
			else if (!locked)
				meas_ind_ff <= IND_NOT_LOCKED_INDICATOR;
			else if (tracking)
				meas_ind_ff <= IND_STAR;
			else
				meas_ind_ff <= IND_NONE;
		end
	end

	// ****************************************
	// event log
	// ****************************************
	assign clr_log = (kv && screen_ff == SCR_EVLOG && key.code == KEY_2
		&& !freq_entry_ff) || (wr_en && paddr == OFS_CTRL && pwdata[CTL_CLR]);
	assign ev_edge = edge_sel_ff[0] ? (event_in && !ev_d_ff)
		: (!event_in && ev_d_ff);
	assign ev_we   = ev_edge && log_en_ff && !meas_en_ff
		&& ev_cnt_ff < (LOG_AW+1)'(LOG_DEPTH) && !clr_log;

	// capture count and browse pointer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ev_d_ff   <= 1'b0;
			ev_cnt_ff <= '0;
			view_ff   <= '0;
		end
		else if (ce)
		begin
			ev_d_ff <= event_in;
			if (clr_log)
			begin
				ev_cnt_ff <= '0;
				view_ff   <= '0;
			end
			else
			begin
				if (ev_we)
					ev_cnt_ff <= ev_cnt_ff + 1'b1;
				if (kv && screen_ff == SCR_EVLOG && key.code == KEY_5 && view_ff != '0)
					view_ff <= view_ff - 1'b1;
				else if (kv && screen_ff == SCR_EVLOG && key.code == KEY_6
					&& (LOG_AW+1)'(view_ff) + 1'b1 < ev_cnt_ff)
					view_ff <= view_ff + 1'b1;
				else if (wr_en && paddr == OFS_EVIDX)
					view_ff <= pwdata[LOG_AW-1:0];
			end
		end
	end

	fpc_evmem #(
		.W     ($bits(fpc_event_t)),
		.DEPTH (LOG_DEPTH),
		.AW    (LOG_AW)
	) u_evmem (
		.pclk     (pclk),
		.ce       (ce),
		.we       (ev_we),
		.waddr    (ev_cnt_ff[LOG_AW-1:0]),
		.wdata    ({EVENT_STATUS_NORMAL, 16'(ev_cnt_ff) + 16'd1, 2'd1, tod}),
		.raddr    (view_ff),
		.rdata_ff (ev_rd)
	);

	// ****************************************
	// apb slave
	// ****************************************
	// answer in the first access cycle; reads latched at setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end
		else if (ce)
		begin
			pready_ff  <= rd_en;
			pslverr_ff <= 1'b0;
			if (rd_en)
			begin
				prdata_ff <= '0;
				unique case (paddr)
					OFS_CTRL:    prdata_ff[7:0] <= {1'b0, edge_sel_ff, lock_ff,
						dst_enable_ff, log_en_ff, meas_en_ff};
					OFS_NOMFREQ: prdata_ff[23:0] <= nom_ff;
					OFS_MUXSEL:  prdata_ff[15:0] <= {mux_sel_ff[3], mux_sel_ff[2],
						mux_sel_ff[1], mux_sel_ff[0]};
					OFS_STATUS:  prdata_ff[9:0] <= {ch_sel_ff, screen_ff, oor_ff,
						scale_ff, log_ind_ff, meas_ind_ff};
					OFS_MEASCNT: prdata_ff[17:0] <= {exp_ff, mant_ff};
					OFS_OFFSET:  prdata_ff[16:0] <= {ofs_neg_ff, ofs_mant_ff};
					OFS_EVIDX:   prdata_ff[12:0] <= {3'(ev_cnt_ff), 6'd0,
						4'(view_ff)};
					OFS_EVD0:    prdata_ff <= ev_rd[31:0];
					OFS_EVD1:    prdata_ff <= ev_rd[63:32];
					OFS_EVD2:    prdata_ff[15:0] <= ev_rd[79:64];
					default:     pslverr_ff <= 1'b1;
				endcase
			end
		end
	end

endmodule : fpc_ctrl

// >>> verification/fpc_ctrl_monitor.sv
`timescale 1ns/10ps
// ****************************************
// port checks of the panel controller
// ****************************************
module fpc_ctrl_monitor
(
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic                   pready_ff,
	input wire logic                   pslverr_ff,
	input wire fpc_pkg::fpc_key_t      key,
	input wire logic                   tracking,
	input wire logic                   locked,
	input wire logic [5:0]             conn_out_ff,
	input wire logic                   ext_pps_ff,
	input wire logic                   ti_enable_ff,
	input wire logic                   dst_enable_ff,
	input wire fpc_pkg::fpc_meas_ind_t meas_ind_ff,
	input wire logic                   log_ind_ff
);
	import fpc_pkg::*;
	logic act;
	// a key or a bus write is the only cause of a setting change
	assign act = key.valid | (psel & penable & pwrite);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************
	// assertions
	// ****************************************
	meas_off_a: assert property (ti_enable_ff [*2] |-> meas_ind_ff == IND_NONE)
		else $error("indicator shown while measurement is off");
	star_ind_a: assert property ((!ti_enable_ff && locked && tracking) [*3]
		|-> meas_ind_ff == IND_STAR) else $error("asterisk missing while tracking");
	not_locked_indicator_ind_a: assert property ((!ti_enable_ff && !locked && !tracking) [*3]
		|-> meas_ind_ff == IND_NOT_LOCKED_INDICATOR) else $error("not locked message missing");
	pps_pulse_a: assert property (ext_pps_ff |=> !ext_pps_ff)
		else $error("divided pulse longer than one cycle");
	log_cause_a: assert property ($changed(log_ind_ff) |-> $past(act) || $past(act, 2))
		else $error("log indicator changed with no cause");
	dst_cause_a: assert property ($changed(dst_enable_ff) |-> $past(act) || $past(act, 2))
		else $error("daylight setting changed with no cause");
	ch1_pair_a: assert property (conn_out_ff[0] == conn_out_ff[5])
		else $error("channel one connectors differ");
	ch2_pair_a: assert property (conn_out_ff[1] == conn_out_ff[4])
		else $error("channel two connectors differ");
	bus_answer_a: assert property (psel && !penable |=> pready_ff)
		else $error("no answer in first access cycle");
	err_ready_a: assert property (pslverr_ff |-> pready_ff)
		else $error("error without ready");

	// main scenarios reached
	cover property (meas_ind_ff == IND_STAR);
	cover property ($rose(log_ind_ff));
	cover property (pslverr_ff);
endmodule : fpc_ctrl_monitor

bind fpc_ctrl fpc_ctrl_monitor u_fpc_ctrl_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
	.key(key), .tracking(tracking), .locked(locked), .conn_out_ff(conn_out_ff),
	.ext_pps_ff(ext_pps_ff), .ti_enable_ff(ti_enable_ff), .dst_enable_ff(dst_enable_ff),
	.meas_ind_ff(meas_ind_ff), .log_ind_ff(log_ind_ff));

// >>> verification/fpc_kpad.sv
`timescale 1ns/10ps
// ****************************************
// front panel keypad
// ****************************************
module fpc_kpad
(
	input wire logic         pclk,
	output fpc_pkg::fpc_key_t key
);
	import fpc_pkg::*;
	initial key = '0;
	// one strobe per press, code not held once the strobe drops
	task automatic press(input logic [3:0] c);
		key <= '{valid: 1'b1, code: c};
		@(posedge pclk);
		key <= '{valid: 1'b0, code: ~c};
		repeat (3) @(posedge pclk);
	endtask : press
endmodule : fpc_kpad

// >>> verification/fpc_ctrl_tb.sv
`timescale 1ns/10ps
module fpc_ctrl_tb;
	import fpc_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pps_tick, tracking, locked;
	logic          ext_freq_in, run_freq, pready_ff, pslverr_ff, er, ev_in;
	logic [39:0]   ofs;
	logic          ext_pps_ff, ti_enable_ff, dst_enable_ff, log_ind_ff;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata_ff, rd, old;
	logic [15:0]   mux_src;
	logic [5:0]    conn_out_ff;
	fpc_meas_ind_t meas_ind_ff;
	fpc_key_t      key;
	int            miscompares, check_count, n, cyc;

	// ****************************************
	// clock, second tick and external frequency
	// ****************************************
	initial
	begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		pps_tick <= (cyc % 50 == 0);
		ext_freq_in <= run_freq & ~ext_freq_in;
	end

	fpc_ctrl u_fpc_ctrl (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .key(key),
		.pps_tick(pps_tick), .tracking(tracking), .locked(locked), .ext_freq_in(ext_freq_in),
		.offset_in(ofs), .offset_noisy(1'b0), .event_in(ev_in), .tod('0),
		.mux_src(mux_src), .conn_out_ff(conn_out_ff), .ext_pps_ff(ext_pps_ff),
		.ti_enable_ff(ti_enable_ff), .dst_enable_ff(dst_enable_ff),
		.meas_ind_ff(meas_ind_ff), .log_ind_ff(log_ind_ff));
	fpc_kpad u_fpc_kpad (.pclk(pclk), .key(key));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one bus transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready_ff !== 1'b1 && t < 16);
		if (pready_ff !== 1'b1)
		begin
			miscompares++;
			give_verdict();
		end
		rd = prdata_ff;
		er = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic k(input logic [3:0] c);
		u_fpc_kpad.press(c);
	endtask : k

	// pulse the event input c times
	task automatic ev(input int c);
		repeat (c)
		begin
			ev_in <= 1'b1;
			@(posedge pclk);
			ev_in <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask : ev

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_reset();
		chk("ti_enable", 1, ti_enable_ff);
		apb(0, OFS_CTRL, 0);
		chk("lock after reset", 0, rd[CTL_LOCK]);
		apb(0, 8'hFC, 0);
		chk("unmapped error", 1, er);
	endtask : s_reset

	task automatic s_freq();
		k(KEY_1);
		for (int i = 7; i >= 0; i--) k((i == 0) ? 4'h4 : 4'h0);
		apb(1, OFS_NOMFREQ, 32'h0098_9681);
		apb(1, OFS_NOMFREQ, 32'h0000_0000);
		apb(0, OFS_NOMFREQ, 0);
		chk("nominal", 4, rd[23:0]);
		apb(1, OFS_CTRL, 32'h0000_0002);
		tracking <= 1'b1;
		locked <= 1'b1;
		k(KEY_2);
		chk("ti off", 0, ti_enable_ff);
		chk("log off", 0, log_ind_ff);
		chk("star", IND_STAR, meas_ind_ff);
		ofs <= 40'h00_0000_4E20;
		@(posedge pclk);
		apb(0, OFS_STATUS, 0);
		chk("scale", SC_E12, rd[4:3]);
		ofs <= 40'hFF_88CA_6C00;
		@(posedge pclk);
		apb(0, OFS_STATUS, 0);
		chk("out of range", {1'b1, SC_E09}, rd[5:3]);
		ofs <= '0;
		apb(0, OFS_MEASCNT, 0);
		old = rd;
		repeat (47) @(posedge pclk);
		apb(0, OFS_MEASCNT, 0);
		chk("count step", old[13:0] + 1, rd[13:0]);
		run_freq <= 1'b1;
		n = 0;
		repeat (80)
		begin
			@(posedge pclk);
			n += (ext_pps_ff === 1'b1);
		end
		run_freq <= 1'b0;
		chk("pulses", 1, n >= 9 && n <= 10);
		locked <= 1'b0;
		tracking <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("not_locked_indicator", IND_NOT_LOCKED_INDICATOR, meas_ind_ff);
		k(KEY_3);
		chk("ti on", 1, ti_enable_ff);
		chk("blank", IND_NONE, meas_ind_ff);
	endtask : s_freq

	task automatic s_log();
		k(KEY_MENU);
		k(KEY_1);
		chk("log stop", 0, log_ind_ff);
		k(KEY_4);
		chk("log on", 1, log_ind_ff);
		apb(0, OFS_CTRL, 0);
		old = rd;
		k(KEY_3);
		apb(0, OFS_CTRL, 0);
		chk("edge step", old[6:4] + 3'h1, rd[6:4]);
		ev(2);
		apb(0, OFS_EVD1, 0);
		chk("first event", 32'h0140_0000, rd);
		apb(0, OFS_EVD2, 0);
		chk("event status", EVENT_STATUS_NORMAL, rd[15:8]);
		k(KEY_6);
		k(KEY_6);
		apb(0, OFS_EVD1, 0);
		chk("next event", 32'h0240_0000, rd);
		k(KEY_5);
		apb(0, OFS_EVD1, 0);
		chk("previous event", 32'h0140_0000, rd);
		k(KEY_2);
		ev(1);
		apb(0, OFS_EVIDX, 0);
		chk("count after clear", 1, rd[12:10]);
		apb(0, OFS_EVD1, 0);
		chk("renumbered", 32'h0140_0000, rd);
		k(KEY_1);
		chk("log blank", 0, log_ind_ff);
	endtask : s_log

	task automatic s_dst();
		k(KEY_MENU);
		k(KEY_1);
		chk("dst on", 1, dst_enable_ff);
		k(KEY_1);
		chk("dst off", 0, dst_enable_ff);
	endtask : s_dst

	task automatic s_mux();
		k(KEY_MENU);
		mux_src <= 16'h0001;
		tracking <= 1'b1;
		apb(1, OFS_MUXSEL, 32'h0000_10CB);
		repeat (3) @(posedge pclk);
		chk("connectors", 6'h25, conn_out_ff);
		apb(0, OFS_MUXSEL, 0);
		chk("mux readback", 32'h0000_10CB, rd);
		k(KEY_2);
		apb(0, OFS_MUXSEL, 0);
		chk("mux step", 32'h0000_10CC, rd);
		chk("locked src", 0, conn_out_ff[0]);
		k(KEY_1);
		k(KEY_2);
		apb(0, OFS_MUXSEL, 0);
		chk("channel step", 32'h0000_10DC, rd);
		k(KEY_3);
		apb(0, OFS_CTRL, 0);
		chk("lock on", 1, rd[CTL_LOCK]);
		k(KEY_2);
		apb(0, OFS_MUXSEL, 0);
		chk("locked key", 32'h0000_10DC, rd);
		repeat (4) k(KEY_MENU);
		k(KEY_3);
		for (int i = 3; i >= 0; i--) k(UNLOCK_CODE[4*i +: 4]);
		apb(0, OFS_CTRL, 0);
		chk("lock off", 0, rd[CTL_LOCK]);
	endtask : s_mux

	initial
	begin
		{presetn, psel, penable, pwrite, tracking, locked, run_freq, ev_in} = '0;
		{paddr, pwdata, mux_src, ofs} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_reset();
		s_freq();
		s_log();
		s_dst();
		s_mux();
		give_verdict();
	end
endmodule : fpc_ctrl_tb
